// ===== hw/ddt_pkg.sv
`default_nettype none
package ddt_pkg;

    localparam int unsigned ADDR_W = 18;
    localparam int unsigned NIB_W  = 4;
    localparam int unsigned CNT_W  = 8;

    // Register indexes; byte address is index times four
    localparam logic [15:0] IDX_T0_MODE   = 16'hFFC0;
    localparam logic [15:0] IDX_OUT_CLK   = 16'hFFC1;
    localparam logic [15:0] IDX_T0_CTRL   = 16'hFFC2;
    localparam logic [15:0] IDX_T1_CTRL   = 16'hFFC3;
    localparam logic [15:0] IDX_T0_RLD_LO = 16'hFFC4;
    localparam logic [15:0] IDX_T0_RLD_HI = 16'hFFC5;
    localparam logic [15:0] IDX_T1_RLD_LO = 16'hFFC6;
    localparam logic [15:0] IDX_T1_RLD_HI = 16'hFFC7;
    localparam logic [15:0] IDX_T0_CNT_LO = 16'hFFC8;
    localparam logic [15:0] IDX_T0_CNT_HI = 16'hFFC9;
    localparam logic [15:0] IDX_T1_CNT_LO = 16'hFFCA;
    localparam logic [15:0] IDX_T1_CNT_HI = 16'hFFCB;
    localparam logic [15:0] IDX_IRQ_MASK  = 16'hFFE2;
    localparam logic [15:0] IDX_IRQ_FLAGS = 16'hFFF2;

    // Field positions
    localparam int unsigned POS_MODE    = 2;
    localparam int unsigned POS_SPARE_A = 1;
    localparam int unsigned POS_SPARE_B = 0;
    localparam int unsigned POS_TOGGLE_CHANNEL_SELECT   = 3;
    localparam int unsigned POS_TOE     = 2;
    localparam int unsigned POS_SRC1    = 1;
    localparam int unsigned POS_SRC0    = 0;
    localparam int unsigned POS_RATIO   = 2;
    localparam int unsigned POS_STROBE  = 1;
    localparam int unsigned POS_RUN     = 0;

    // Prescaler terminal counts for /1, /4, /32, /256
    localparam logic [7:0] PRE_TERM_1   = 8'h00;
    localparam logic [7:0] PRE_TERM_4   = 8'h03;
    localparam logic [7:0] PRE_TERM_32  = 8'h1F;
    localparam logic [7:0] PRE_TERM_256 = 8'hFF;

    localparam logic [7:0] RELOAD_RST = 8'h00;
    localparam logic [7:0] COUNT_RST  = 8'h00;

    typedef struct packed {
        logic [1:0] ratio;
        logic       run;
        logic       src;
    } ddt_cfg_type;

    localparam ddt_cfg_type CFG_RST = '{ratio: 2'h0, run: 1'b0, src: 1'b0};

endpackage : ddt_pkg
`default_nettype wire

// ===== hw/ddt_timer.sv
`default_nettype none
// How it works
// - Underflow sets flag and requests interrupt
// - Flag sets even while masked
// - Per-timer mask bit gates the request
// - Toggle output flips on each underflow of the timer picked by channel select
// - Channel select picks timer 0 or 1
// - Enable passes toggle, otherwise pin high
// - Enable gates toggle without any resync
// - Timer 1 halved underflow feeds serial clock
// - Source bit picks slow or fast clock
// - Reserved mode stops timer 0 clocking
// - Reload on strobe write and underflow
// - Reload registers reset to zero
// - Count readable as low and high nibble
// - Unused bits read as zero
// - Source selects reset to slow clock
// - Writing one clears a flag
// - Strobe reload write also loads run from bit 0; reads zero
// - Low nibble read latches high nibble
// - Run bit starts and stops, count kept
module ddt_timer (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [ddt_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       slow_osc_clock,
    input  wire logic                       fast_osc_clock,
    output logic                            shared_output_pin,
    output logic                            timer_toggle_out,
    output logic                            sio_clock,
    output logic                            timer_irq
);

    // Address decode
    wire         setup_ph  = psel & ~penable;
    wire         access_ph = psel & penable;
    wire         wr_acc    = access_ph & pwrite;
    wire         rd_acc    = access_ph & ~pwrite;
    wire         hit_mode  = paddr == {ddt_pkg::IDX_T0_MODE, 2'b00};
    wire         hit_oclk  = paddr == {ddt_pkg::IDX_OUT_CLK, 2'b00};
    wire         hit_c0    = paddr == {ddt_pkg::IDX_T0_CTRL, 2'b00};
    wire         hit_c1    = paddr == {ddt_pkg::IDX_T1_CTRL, 2'b00};
    wire         hit_r0l   = paddr == {ddt_pkg::IDX_T0_RLD_LO, 2'b00};
    wire         hit_r0h   = paddr == {ddt_pkg::IDX_T0_RLD_HI, 2'b00};
    wire         hit_r1l   = paddr == {ddt_pkg::IDX_T1_RLD_LO, 2'b00};
    wire         hit_r1h   = paddr == {ddt_pkg::IDX_T1_RLD_HI, 2'b00};
    wire         hit_n0l   = paddr == {ddt_pkg::IDX_T0_CNT_LO, 2'b00};
    wire         hit_n0h   = paddr == {ddt_pkg::IDX_T0_CNT_HI, 2'b00};
    wire         hit_n1l   = paddr == {ddt_pkg::IDX_T1_CNT_LO, 2'b00};
    wire         hit_n1h   = paddr == {ddt_pkg::IDX_T1_CNT_HI, 2'b00};
    wire         hit_msk   = paddr == {ddt_pkg::IDX_IRQ_MASK, 2'b00};
    wire         hit_flg   = paddr == {ddt_pkg::IDX_IRQ_FLAGS, 2'b00};
    wire         hit_any   = hit_mode | hit_oclk | hit_c0 | hit_c1 | hit_r0l | hit_r0h
                             | hit_r1l | hit_r1h | hit_n0l | hit_n0h | hit_n1l | hit_n1h
                             | hit_msk | hit_flg;
    wire [3:0]   wnib      = pwdata[3:0];

    // Register state
    logic [2:0]                 mode_q;
    logic                       toggle_channel_select_q;
    logic                       toe_q;
    ddt_pkg::ddt_cfg_type       cfg_q [2];
    logic [ddt_pkg::CNT_W-1:0]  reload_q [2];
    logic [ddt_pkg::CNT_W-1:0]  cnt_q [2];
    logic [7:0]                 pre_q [2];
    logic [ddt_pkg::NIB_W-1:0]  hold_q [2];
    logic [1:0]                 mask_q;
    logic [1:0]                 flag_q;
    logic                       timer_toggle_out_q;
    logic                       sio_q;
    logic [31:0]                prdata_q;
    logic                       pslverr_q;

    // Oscillator inputs: two-stage sync then edge detect
    logic [1:0] osc_s1_q;
    logic [1:0] osc_s2_q;
    logic [1:0] osc_prev_q;
    wire  [1:0] osc_edge = osc_s2_q & ~osc_prev_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_s1_q   <= 2'h0;
            osc_s2_q   <= 2'h0;
            osc_prev_q <= 2'h0;
        end else begin
            osc_s1_q   <= {fast_osc_clock, slow_osc_clock};
            osc_s2_q   <= osc_s1_q;
            osc_prev_q <= osc_s2_q;
        end
    end

    // Per-timer write strobes and low count read strobe
    wire [1:0] ctrl_wr   = {wr_acc & hit_c1, wr_acc & hit_c0};
    wire [1:0] rld_lo_wr = {wr_acc & hit_r1l, wr_acc & hit_r0l};
    wire [1:0] rld_hi_wr = {wr_acc & hit_r1h, wr_acc & hit_r0h};
    wire [1:0] cnt_lo_rd = {setup_ph & ~pwrite & hit_n1l, setup_ph & ~pwrite & hit_n0l};
    wire [1:0] strobe    = ctrl_wr & {2{wnib[ddt_pkg::POS_STROBE]}};
    wire       flag_wr   = wr_acc & hit_flg;
    wire [1:0] tick;
    wire [1:0] uf;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_tmr
            wire       src_ev = cfg_q[gi].src ? osc_edge[1] : osc_edge[0];
            wire       blocked = (gi == 0) ? mode_q[ddt_pkg::POS_MODE] : 1'b0;
            wire [7:0] term   = (cfg_q[gi].ratio == 2'h0) ? ddt_pkg::PRE_TERM_1 :
                                (cfg_q[gi].ratio == 2'h1) ? ddt_pkg::PRE_TERM_4 :
                                (cfg_q[gi].ratio == 2'h2) ? ddt_pkg::PRE_TERM_32 :
                                                            ddt_pkg::PRE_TERM_256;
            wire       pre_go = cfg_q[gi].run & ~blocked & src_ev;
            assign tick[gi] = pre_go & (pre_q[gi] == term) & ~strobe[gi];
            assign uf[gi]   = tick[gi] & (cnt_q[gi] == ddt_pkg::COUNT_RST);

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cfg_q[gi]    <= ddt_pkg::CFG_RST;
                    reload_q[gi] <= ddt_pkg::RELOAD_RST;
                    cnt_q[gi]    <= ddt_pkg::COUNT_RST;
                    pre_q[gi]    <= 8'h00;
                    hold_q[gi]   <= 4'h0;
                end else begin
                    if (ctrl_wr[gi]) begin
                        cfg_q[gi].ratio <= wnib[ddt_pkg::POS_RATIO +: 2];
                        cfg_q[gi].run   <= wnib[ddt_pkg::POS_RUN];
                    end
                    if (wr_acc & hit_oclk) begin
                        cfg_q[gi].src <= wnib[gi];
                    end
                    if (rld_lo_wr[gi]) begin
                        reload_q[gi][3:0] <= wnib;
                    end
                    if (rld_hi_wr[gi]) begin
                        reload_q[gi][7:4] <= wnib;
                    end
                    if (strobe[gi]) begin
                        cnt_q[gi] <= reload_q[gi];
                        pre_q[gi] <= 8'h00;
                    end else if (tick[gi]) begin
                        cnt_q[gi] <= uf[gi] ? reload_q[gi] : cnt_q[gi] - 8'h01;
                        pre_q[gi] <= 8'h00;
                    end else if (pre_go) begin
                        pre_q[gi] <= pre_q[gi] + 8'h01;
                    end
                    if (cnt_lo_rd[gi]) begin
                        hold_q[gi] <= cnt_q[gi][7:4];
                    end
                end
            end
        end
    endgenerate

    // Mode, output select, mask, flags, toggles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q  <= 3'h0;
            toggle_channel_select_q <= 1'b0;
            toe_q   <= 1'b0;
            mask_q  <= 2'h0;
            flag_q  <= 2'h0;
            timer_toggle_out_q  <= 1'b0;
            sio_q   <= 1'b0;
        end else begin
            if (wr_acc & hit_mode) begin
                mode_q <= wnib[2:0];
            end
            if (wr_acc & hit_oclk) begin
                toggle_channel_select_q <= wnib[ddt_pkg::POS_TOGGLE_CHANNEL_SELECT];
                toe_q   <= wnib[ddt_pkg::POS_TOE];
            end
            if (wr_acc & hit_msk) begin
                mask_q <= wnib[1:0];
            end
            flag_q <= uf | (flag_q & ~({2{flag_wr}} & wnib[1:0]));
            timer_toggle_out_q <= timer_toggle_out_q ^ (toggle_channel_select_q ? uf[1] : uf[0]);
            sio_q  <= sio_q ^ uf[1];
        end
    end

    // Read mux, unused bits zero
    logic [3:0] rd_nib;
    always_comb begin
        rd_nib = 4'h0;
        if (hit_mode) begin
            rd_nib = {1'b0, mode_q};
        end else if (hit_oclk) begin
            rd_nib = {toggle_channel_select_q, toe_q, cfg_q[1].src, cfg_q[0].src};
        end else if (hit_c0) begin
            rd_nib = {cfg_q[0].ratio, 1'b0, cfg_q[0].run};
        end else if (hit_c1) begin
            rd_nib = {cfg_q[1].ratio, 1'b0, cfg_q[1].run};
        end else if (hit_r0l) begin
            rd_nib = reload_q[0][3:0];
        end else if (hit_r0h) begin
            rd_nib = reload_q[0][7:4];
        end else if (hit_r1l) begin
            rd_nib = reload_q[1][3:0];
        end else if (hit_r1h) begin
            rd_nib = reload_q[1][7:4];
        end else if (hit_n0l) begin
            rd_nib = cnt_q[0][3:0];
        end else if (hit_n0h) begin
            rd_nib = hold_q[0];
        end else if (hit_n1l) begin
            rd_nib = cnt_q[1][3:0];
        end else if (hit_n1h) begin
            rd_nib = hold_q[1];
        end else if (hit_msk) begin
            rd_nib = {2'h0, mask_q};
        end else if (hit_flg) begin
            rd_nib = {2'h0, flag_q};
        end
    end

    // Read data and error captured in setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (setup_ph) begin
            prdata_q  <= {28'h000_0000, rd_nib};
            pslverr_q <= ~hit_any;
        end
    end

    assign prdata            = prdata_q;
    assign pready            = access_ph;
    assign pslverr           = access_ph & pslverr_q;
    assign timer_toggle_out  = timer_toggle_out_q;
    assign shared_output_pin = toe_q ? timer_toggle_out_q : 1'b1;
    assign sio_clock         = sio_q;
    assign timer_irq         = |(flag_q & mask_q);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_flag_set;
        uf[0] |=> flag_q[0];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("t0 flag not set");

    property p_flag_masked;
        uf[1] && !mask_q[1] |=> flag_q[1];
    endproperty
    a_flag_masked: assert property (p_flag_masked) else $error("masked flag lost");

    property p_irq_req;
        $rose(flag_q[0]) && mask_q[0] |-> timer_irq;
    endproperty
    a_irq_req: assert property (p_irq_req) else $error("no irq request");

    property p_irq_mask;
        mask_q == 2'h0 |-> !timer_irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked irq raised");

    property p_toggle;
        (toggle_channel_select_q ? uf[1] : uf[0]) |=> timer_toggle_out != $past(timer_toggle_out);
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle missed");

    property p_pin_high;
        !toe_q |-> shared_output_pin;
    endproperty
    a_pin_high: assert property (p_pin_high) else $error("pin not high");

    property p_sio;
        uf[1] |=> sio_clock != $past(sio_clock);
    endproperty
    a_sio: assert property (p_sio) else $error("serial clock missed");

    property p_strobe_load;
        strobe[0] |=> cnt_q[0] == $past(reload_q[0]);
    endproperty
    a_strobe_load: assert property (p_strobe_load) else $error("strobe reload bad");

    property p_uf_load;
        uf[1] |=> cnt_q[1] == $past(reload_q[1]);
    endproperty
    a_uf_load: assert property (p_uf_load) else $error("underflow reload bad");

    property p_clear;
        flag_wr && pwdata[0] && !uf[0] |=> !flag_q[0];
    endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared");

    property p_hold;
        !cfg_q[1].run && !strobe[1] |=> $stable(cnt_q[1]);
    endproperty
    a_hold: assert property (p_hold) else $error("stopped count moved");

    property p_mode_block;
        mode_q[ddt_pkg::POS_MODE] |-> !tick[0];
    endproperty
    a_mode_block: assert property (p_mode_block) else $error("reserved mode ticked");

    property p_rd_zero;
        rd_acc && (hit_msk || hit_flg) |-> prdata[31:2] == 30'h0000_0000;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("unused bits nonzero");

    property p_flag_set1;
        uf[1] |=> flag_q[1];
    endproperty
    a_flag_set1: assert property (p_flag_set1) else $error("t1 flag not set");

    property p_pin_tog;
        toe_q |-> shared_output_pin == timer_toggle_out;
    endproperty
    a_pin_tog: assert property (p_pin_tog) else $error("pin not toggle");

    property p_no_toggle;
        !(toggle_channel_select_q ? uf[1] : uf[0]) |=> $stable(timer_toggle_out);
    endproperty
    a_no_toggle: assert property (p_no_toggle) else $error("stray toggle");

    property p_sio_hold;
        !uf[1] |=> $stable(sio_clock);
    endproperty
    a_sio_hold: assert property (p_sio_hold) else $error("stray serial edge");

    property p_strobe_load1;
        strobe[1] |=> cnt_q[1] == $past(reload_q[1]);
    endproperty
    a_strobe_load1: assert property (p_strobe_load1) else $error("t1 strobe");

    property p_uf_load0;
        uf[0] |=> cnt_q[0] == $past(reload_q[0]);
    endproperty
    a_uf_load0: assert property (p_uf_load0) else $error("t0 reload bad");

    property p_hold0;
        !cfg_q[0].run && !strobe[0] |=> $stable(cnt_q[0]);
    endproperty
    a_hold0: assert property (p_hold0) else $error("t0 count moved");

    property p_count_down;
        tick[0] && (cnt_q[0] != 8'h00) |=> cnt_q[0] == $past(cnt_q[0]) - 8'h01;
    endproperty
    a_count_down: assert property (p_count_down) else $error("bad decrement");

    property p_ratio4;
        tick[1] && (cfg_q[1].ratio == 2'h1) |-> pre_q[1] == ddt_pkg::PRE_TERM_4;
    endproperty
    a_ratio4: assert property (p_ratio4) else $error("ratio four wrong");

    property p_latch;
        cnt_lo_rd[0] |=> hold_q[0] == $past(cnt_q[0][7:4]);
    endproperty
    a_latch: assert property (p_latch) else $error("high nibble not held");

    property p_strobe_rd;
        rd_acc && hit_c0 |-> prdata[1] == 1'b0;
    endproperty
    a_strobe_rd: assert property (p_strobe_rd) else $error("strobe bit read");

    property p_rd_unused;
        rd_acc |-> prdata[31:4] == 28'h000_0000;
    endproperty
    a_rd_unused: assert property (p_rd_unused) else $error("upper bits nonzero");

    c_uf0: cover property (uf[0]);
    c_uf1_irq: cover property (uf[1] ##1 timer_irq);
    c_latch: cover property (cnt_lo_rd[0] ##[1:20] (rd_acc && hit_n0h));
    c_toggle_pin: cover property (toe_q && $changed(shared_output_pin));
    c_strobe: cover property (strobe[1] && cfg_q[1].run);

endmodule : ddt_timer
`default_nettype wire

// ===== bench/test_dual_down_timer_irq_timer_toggle_out.sv
`default_nettype none
module test_dual_down_timer_irq_timer_toggle_out;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic        pready, pslverr, slow_osc_clock, fast_osc_clock;
    logic        shared_output_pin, timer_toggle_out, sio_clock, timer_irq;
    int          error_cnt, n_tests, seed, pre[2];
    logic [7:0]  rld[2], cnt[2];
    logic [3:0]  hl[2];
    logic [1:0]  rat[2], src, run, mask, flag;
    logic        mode, spa, spb, toggle_channel_select, toe, tog, sio;
    logic [15:0] regs[$] = '{16'hFFC0, 16'hFFC1, 16'hFFC2, 16'hFFC3, 16'hFFC4, 16'hFFC5,
        16'hFFC6, 16'hFFC7, 16'hFFC8, 16'hFFC9, 16'hFFCA, 16'hFFCB, 16'hFFE2, 16'hFFF2,
        16'hFFCC, 16'hFFE3};

    ddt_timer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .slow_osc_clock, .fast_osc_clock, .shared_output_pin,
        .timer_toggle_out, .sio_clock, .timer_irq);

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL %0t read %h expected %h", $time, g, e);
        end
    endtask : chk_word

    task automatic chk_bit(input logic g, input logic e);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL %0t flag %b expected %b", $time, g, e);
        end
    endtask : chk_bit

    function automatic logic mapped(input logic [15:0] idx);
        return idx inside {[16'hFFC0:16'hFFCB], 16'hFFE2, 16'hFFF2};
    endfunction : mapped

    function automatic int dv(input logic [1:0] q);
        return (q == 2'h0) ? 1 : (q == 2'h1) ? 4 : (q == 2'h2) ? 32 : 256;
    endfunction : dv

    function automatic logic [3:0] exp_rd(input logic [15:0] idx);
        case (idx) inside
            16'hFFC0: return {1'b0, mode, spa, spb};
            16'hFFC1: return {toggle_channel_select, toe, src};
            16'hFFC2, 16'hFFC3: return {rat[idx[0]], 1'b0, run[idx[0]]};
            [16'hFFC4:16'hFFC7]: return idx[0] ? rld[idx[1]][7:4] : rld[idx[1]][3:0];
            16'hFFC8, 16'hFFCA: return cnt[idx[1]][3:0];
            16'hFFC9, 16'hFFCB: return hl[idx[1]];
            16'hFFE2: return {2'h0, mask};
            16'hFFF2: return {2'h0, flag};
            default: return 4'h0;
        endcase
    endfunction : exp_rd

    task automatic apb(input logic w, input logic [15:0] idx, input logic [3:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {idx, 2'h0};
        pwdata  <= {28'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [15:0] idx);
        logic [31:0] q;
        logic [31:0] x;
        logic        e;
        x = {28'h0, exp_rd(idx)};
        if (idx inside {16'hFFC8, 16'hFFCA}) hl[idx[1]] = cnt[idx[1]][7:4];
        apb(1'b0, idx, 4'h0, q, e);
        chk_word(q, x);
        chk_bit(e, ~mapped(idx));
    endtask : rd

    task automatic wr(input logic [15:0] idx, input logic [3:0] d);
        logic [31:0] q;
        logic        e;
        int          t;
        t = idx[0];
        apb(1'b1, idx, d, q, e);
        chk_bit(e, ~mapped(idx));
        case (idx) inside
            16'hFFC0: {mode, spa, spb} = d[2:0];
            16'hFFC1: {toggle_channel_select, toe, src} = d;
            16'hFFC2, 16'hFFC3: begin
                rat[t] = d[3:2];
                run[t] = d[0];
                if (d[1]) begin
                    cnt[t] = rld[t];
                    pre[t] = 0;
                end
            end
            [16'hFFC4:16'hFFC7]: if (idx[0]) rld[idx[1]][7:4] = d; else rld[idx[1]][3:0] = d;
            16'hFFE2: mask = d[1:0];
            16'hFFF2: flag = flag & ~d[1:0];
            default: ;
        endcase
    endtask : wr

    task automatic osc_edge(input logic [1:0] s);
        @(posedge pclk);
        slow_osc_clock <= s[0];
        fast_osc_clock <= s[1];
        repeat (4) @(posedge pclk);
        slow_osc_clock <= 1'b0;
        fast_osc_clock <= 1'b0;
        repeat (4) @(posedge pclk);
        for (int t = 0; t < 2; t++) begin
            if (s[src[t]] && run[t] && !(t == 0 && mode)) begin
                pre[t]++;
                if (pre[t] >= dv(rat[t])) begin
                    pre[t] = 0;
                    if (cnt[t] == 8'h00) begin
                        cnt[t] = rld[t];
                        flag[t] = 1'b1;
                        if (toggle_channel_select == t) tog = ~tog;
                        if (t == 1) sio = ~sio;
                    end else begin
                        cnt[t]--;
                    end
                end
            end
        end
    endtask : osc_edge

    task automatic chk_all;
        @(negedge pclk);
        chk_bit(timer_toggle_out, tog);
        chk_bit(shared_output_pin, toe ? tog : 1'b1);
        chk_bit(sio_clock, sio);
        chk_bit(timer_irq, |(flag & mask));
        rd(16'hFFF2);
        for (int i = 8; i < 12; i++) rd(regs[i]);
    endtask : chk_all

    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results

    initial begin
        repeat (40000) @(posedge pclk);
        error_cnt++;
        $display("FAIL %0t watchdog expired", $time);
        results();
    end

    initial begin
        seed = 32'h8518644E;
        {psel, penable, pwrite, slow_osc_clock, fast_osc_clock, presetn} = 6'h0;
        paddr = 18'h0;
        pwdata = 32'h0;
        {mode, spa, spb, toggle_channel_select, toe, tog, sio, src, run, mask, flag} = 15'h0;
        for (int t = 0; t < 2; t++) begin
            rld[t] = 8'h00;
            cnt[t] = 8'h00;
            hl[t] = 4'h0;
            rat[t] = 2'h0;
            pre[t] = 0;
        end
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        foreach (regs[i]) rd(regs[i]);
        chk_all;
        $display("test reset done");
        repeat (3) foreach (regs[i]) begin
            wr(regs[i], 4'($random(seed)));
            rd(regs[i]);
        end
        $display("test registers done");
        wr(16'hFFC4, 4'($random(seed)));
        wr(16'hFFC5, 4'h0);
        wr(16'hFFC6, 4'($random(seed)));
        wr(16'hFFC7, 4'h0);
        wr(16'hFFC2, 4'h3);
        wr(16'hFFC3, 4'h3);
        repeat (250) begin
            r = $random(seed);
            case (r[2:0])
                3'h3: wr(16'hFFF2, r[7:4]);
                3'h4: wr(16'hFFC1, r[7:4]);
                3'h5: wr(16'hFFE2, r[7:4]);
                3'h6: begin
                    wr(16'hFFC2 | 16'(r[4]), {2'h0, r[6:5]});
                    wr(16'hFFC0, {1'b0, r[9:7]});
                end
                3'h7: begin
                    rd(16'hFFC8 | 16'({r[4], 1'b0}));
                    osc_edge(2'h3);
                    rd(16'hFFC9 | 16'({r[4], 1'b0}));
                end
                default: osc_edge(r[5:4]);
            endcase
            chk_all;
        end
        $display("test random traffic done");
        wr(16'hFFC0, 4'h0);
        wr(16'hFFC1, 4'h2);
        wr(16'hFFE2, 4'h2);
        wr(16'hFFC6, 4'h0);
        wr(16'hFFC7, 4'h0);
        for (int k = 0; k < 4; k++) begin
            wr(16'hFFC3, {2'(k), 2'h3});
            wr(16'hFFF2, 4'h3);
            osc_edge(2'h1);
            repeat (dv(2'(k)) - 1) osc_edge(2'h2);
            chk_all;
            osc_edge(2'h2);
            chk_all;
        end
        $display("test ratios done");
        results();
    end
endmodule : test_dual_down_timer_irq_timer_toggle_out
`default_nettype wire
